// File: common/ddp_pkg.sv
package ddp_pkg;
  localparam int DQ_LINES = 36;
  localparam int DATA_BITS = 32;
  localparam int BYTES = 4;
  localparam int BYTE_W = 8;
  localparam int GROUPS = 4;
  localparam int PAR_BASE = 32;
  localparam int FIFO_AW = 2;
  localparam int FIFO_DEPTH = 4;
  localparam int WORD_W = 2 * DQ_LINES;
  localparam int ERR_W = 2 * BYTES;
  localparam int BUF_W = WORD_W + ERR_W;
  localparam logic [3:0] DM_ALL = 4'hF;
  localparam logic [3:0] DM_X16 = 4'h3;
  localparam logic [3:0] DM_X32 = 4'h1;

  typedef enum logic [2:0] {
    MODE_X8 = 3'h0,
    MODE_X9 = 3'h1,
    MODE_X16 = 3'h2,
    MODE_X18 = 3'h3,
    MODE_X32 = 3'h4,
    MODE_X36 = 3'h5
  } ddp_mode_t;

  typedef enum logic {
    MEM_SDRAM = 1'h0,
    MEM_QDR = 1'h1
  } ddp_mem_t;

  // Mask lines that exist, one per strobe group
  function automatic logic [3:0] dm_lines(input ddp_mode_t m);
    dm_lines = (m == MODE_X8 || m == MODE_X9) ? DM_ALL :
               (m == MODE_X16 || m == MODE_X18) ? DM_X16 : DM_X32;
  endfunction

  function automatic logic par_on(input ddp_mode_t m);
    par_on = (m == MODE_X9 || m == MODE_X18 || m == MODE_X36);
  endfunction

  // Group is written when any of its bytes is enabled
  function automatic logic [3:0] grp_wr(input ddp_mode_t m, input logic [3:0] be);
    if (m == MODE_X8 || m == MODE_X9)
      grp_wr = be;
    else if (m == MODE_X16 || m == MODE_X18)
      grp_wr = {2'h0, |be[3:2], |be[1:0]};
    else
      grp_wr = {3'h0, |be};
  endfunction

  function automatic logic [3:0] byte_par(input logic [31:0] d);
    byte_par = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction

  function automatic logic [2:0] bin2gray(input logic [2:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction
endpackage

// File: common/ddp_stream_if.sv
`timescale 1ns/1ps
interface ddp_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// File: design/ddp_mem_io.sv
`timescale 1ns/1ps
module ddp_mem_io (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic cap_clk_i,
  input wire logic [ddp_pkg::DQ_LINES-1:0] rd_dq_i,
  input wire logic rd_en_i,
  output logic [ddp_pkg::WORD_W-1:0] rd_data_o,
  output logic [ddp_pkg::ERR_W-1:0] rd_par_err_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic rd_overflow_o,
  input wire logic ovf_clr_i,
  input wire logic [2:0] mode_i,
  input wire logic mem_qdr_i,
  input wire logic wr_valid_i,
  input wire logic [2*ddp_pkg::DATA_BITS-1:0] wr_data_i,
  input wire logic [2*ddp_pkg::BYTES-1:0] wr_be_i,
  output logic wr_ready_o,
  output logic [ddp_pkg::DQ_LINES-1:0] dq_hi_o,
  output logic [ddp_pkg::DQ_LINES-1:0] dq_lo_o,
  output logic [ddp_pkg::DQ_LINES-1:0] dq_oe_o,
  output logic [ddp_pkg::GROUPS-1:0] dm_hi_o,
  output logic [ddp_pkg::GROUPS-1:0] dm_lo_o,
  output logic [ddp_pkg::GROUPS-1:0] dm_oe_o
);
  localparam int DL = ddp_pkg::DQ_LINES;
  localparam int DB = ddp_pkg::DATA_BITS;
  localparam int PB = ddp_pkg::PAR_BASE;
  localparam int NB = ddp_pkg::BYTES;

  ddp_pkg::ddp_mode_t mode;
  ddp_pkg::ddp_mem_t mem_kind;
  assign mode = ddp_pkg::ddp_mode_t'(mode_i);
  assign mem_kind = ddp_pkg::ddp_mem_t'(mem_qdr_i);
  wire par_mode = ddp_pkg::par_on(mode);
  wire [3:0] dm_exist = ddp_pkg::dm_lines(mode);

  // Capture-clock domain reset and enable
  logic cap_rst_s1_reg, cap_rst_reg;
  logic rd_en_reg, en_s1_reg, en_s2_reg;
  always_ff @(posedge sys_clk_i) begin
    rd_en_reg <= rst_i ? 1'b0 : rd_en_i;
  end
  always_ff @(posedge cap_clk_i) begin
    cap_rst_s1_reg <= rst_i;
    cap_rst_reg <= cap_rst_s1_reg;
    en_s1_reg <= rd_en_reg;
    en_s2_reg <= en_s1_reg;
  end

  // Double-rate capture on the PLL capture clock
  logic [DL-1:0] rise_reg, fall_reg, align_reg, hold_hi_reg, hold_lo_reg;
  logic cv1_reg, cv2_reg;
  always_ff @(posedge cap_clk_i) begin
    rise_reg <= rd_dq_i;
    align_reg <= fall_reg;
  end
  always_ff @(negedge cap_clk_i) begin
    fall_reg <= rd_dq_i;
  end
  always_ff @(posedge cap_clk_i) begin
    hold_hi_reg <= rise_reg;
    hold_lo_reg <= align_reg;
    cv1_reg <= cap_rst_reg ? 1'b0 : en_s2_reg;
    cv2_reg <= cap_rst_reg ? 1'b0 : cv1_reg;
  end

  // Dual-clock FIFO with gray pointers
  localparam int FIFO_AW_P = ddp_pkg::FIFO_AW;
  logic [ddp_pkg::WORD_W-1:0] fifo_mem [ddp_pkg::FIFO_DEPTH];
  logic [FIFO_AW_P:0] wbin_reg, wgray_reg, rq1_reg, rq2_reg;
  logic [FIFO_AW_P:0] rbin_reg, rgray_reg, wq1_reg, wq2_reg;
  logic ovf_tgl_reg;
  wire [FIFO_AW_P:0] wbin_inc = wbin_reg + 3'h1;
  wire [FIFO_AW_P:0] rbin_inc = rbin_reg + 3'h1;
  wire fifo_full = wgray_reg == {~rq2_reg[2:1], rq2_reg[0]};
  wire fifo_empty = rgray_reg == wq2_reg;
  wire fifo_push = cv2_reg && !fifo_full;
  wire fifo_drop = cv2_reg && fifo_full;

  always_ff @(posedge cap_clk_i) begin
    if (fifo_push) begin
      fifo_mem[wbin_reg[FIFO_AW_P-1:0]] <= {hold_hi_reg, hold_lo_reg};
    end
  end
  always_ff @(posedge cap_clk_i) begin
    if (cap_rst_reg) begin
      wbin_reg <= 3'h0;
      wgray_reg <= 3'h0;
      rq1_reg <= 3'h0;
      rq2_reg <= 3'h0;
      ovf_tgl_reg <= 1'b0;
    end else begin
      wbin_reg <= fifo_push ? wbin_inc : wbin_reg;
      wgray_reg <= fifo_push ? ddp_pkg::bin2gray(wbin_inc) : wgray_reg;
      rq1_reg <= rgray_reg;
      rq2_reg <= rq1_reg;
      ovf_tgl_reg <= ovf_tgl_reg ^ fifo_drop;
    end
  end

  // System-clock side of the FIFO
  ddp_stream_if #(.W(ddp_pkg::BUF_W)) buf_in ();
  ddp_stream_if #(.W(ddp_pkg::BUF_W)) buf_out ();
  wire [ddp_pkg::WORD_W-1:0] head = fifo_mem[rbin_reg[FIFO_AW_P-1:0]];
  wire [DL-1:0] head_hi = head[ddp_pkg::WORD_W-1:DL];
  wire [DL-1:0] head_lo = head[DL-1:0];
  wire [3:0] perr_hi = ddp_pkg::byte_par(head_hi[DB-1:0]) ^ head_hi[DL-1:PB];
  wire [3:0] perr_lo = ddp_pkg::byte_par(head_lo[DB-1:0]) ^ head_lo[DL-1:PB];
  wire [ddp_pkg::ERR_W-1:0] perr = par_mode ? {perr_hi, perr_lo} : '0;
  wire fifo_pop = !fifo_empty && buf_in.ready;
  assign buf_in.valid = !fifo_empty;
  assign buf_in.data = {perr, head};

  logic ovf_s1_reg, ovf_s2_reg, ovf_s3_reg, ovf_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rbin_reg <= 3'h0;
      rgray_reg <= 3'h0;
      wq1_reg <= 3'h0;
      wq2_reg <= 3'h0;
      ovf_s1_reg <= 1'b0;
      ovf_s2_reg <= 1'b0;
      ovf_s3_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      rbin_reg <= fifo_pop ? rbin_inc : rbin_reg;
      rgray_reg <= fifo_pop ? ddp_pkg::bin2gray(rbin_inc) : rgray_reg;
      wq1_reg <= wgray_reg;
      wq2_reg <= wq1_reg;
      ovf_s1_reg <= ovf_tgl_reg;
      ovf_s2_reg <= ovf_s1_reg;
      ovf_s3_reg <= ovf_s2_reg;
      // Set wins over clear
      ovf_reg <= (ovf_s2_reg ^ ovf_s3_reg) || (ovf_reg && !ovf_clr_i);
    end
  end

  ddp_skid_buf u_buf (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_s(buf_in),
    .out_s(buf_out)
  );
  assign buf_out.ready = rd_ready_i;
  assign rd_valid_o = buf_out.valid;
  assign rd_data_o = buf_out.data[ddp_pkg::WORD_W-1:0];
  assign rd_par_err_o = buf_out.data[ddp_pkg::BUF_W-1:ddp_pkg::WORD_W];
  assign rd_overflow_o = ovf_reg;

  // Write launch, data and masks from one register stage
  logic wr_ready_reg;
  logic [DL-1:0] dq_hi_reg, dq_lo_reg, dq_oe_reg;
  logic [3:0] dm_hi_reg, dm_lo_reg, dm_oe_reg;
  wire wr_fire = wr_valid_i && wr_ready_reg;
  wire [DB-1:0] wd_hi = wr_data_i[2*DB-1:DB];
  wire [DB-1:0] wd_lo = wr_data_i[DB-1:0];
  wire [3:0] par_hi = par_mode ? ddp_pkg::byte_par(wd_hi) : 4'h0;
  wire [3:0] par_lo = par_mode ? ddp_pkg::byte_par(wd_lo) : 4'h0;
  wire [3:0] wr_grp_hi = wr_fire ? ddp_pkg::grp_wr(mode, wr_be_i[2*NB-1:NB]) : 4'h0;
  wire [3:0] wr_grp_lo = wr_fire ? ddp_pkg::grp_wr(mode, wr_be_i[NB-1:0]) : 4'h0;
  wire [3:0] dm_hi_next = ~wr_grp_hi & dm_exist;
  wire [3:0] dm_lo_next = ~wr_grp_lo & dm_exist;
  wire [3:0] par_oe = par_mode ? 4'hF : 4'h0;
  wire [DL-1:0] dq_oe_next = wr_fire ? {par_oe, {DB{1'b1}}} : '0;
  // QDR selects stay driven; SDRAM masks only during writes
  wire [3:0] dm_oe_next = (mem_kind == ddp_pkg::MEM_QDR || wr_fire) ? dm_exist : 4'h0;

  always_ff @(posedge sys_clk_i) begin
    wr_ready_reg <= !rst_i;
    dq_hi_reg <= {par_hi, wd_hi};
    dq_lo_reg <= {par_lo, wd_lo};
    dm_hi_reg <= rst_i ? 4'h0 : dm_hi_next;
    dm_lo_reg <= rst_i ? 4'h0 : dm_lo_next;
    dq_oe_reg <= rst_i ? '0 : dq_oe_next;
    dm_oe_reg <= rst_i ? 4'h0 : dm_oe_next;
  end
  assign wr_ready_o = wr_ready_reg;
  assign dq_hi_o = dq_hi_reg;
  assign dq_lo_o = dq_lo_reg;
  assign dq_oe_o = dq_oe_reg;
  assign dm_hi_o = dm_hi_reg;
  assign dm_lo_o = dm_lo_reg;
  assign dm_oe_o = dm_oe_reg;

  // Checks in the capture domain
  chk_rise_sample_path: assert property (
    @(posedge cap_clk_i) disable iff (cap_rst_reg)
    ##2 hold_hi_reg == $past(rd_dq_i, 2))
    else $error("rising sample not in high half");

  chk_fall_sample_taken: assert property (
    @(negedge cap_clk_i) disable iff (cap_rst_reg)
    ##1 fall_reg == $past(rd_dq_i))
    else $error("falling sample not captured");

  chk_align_low_half: assert property (
    @(posedge cap_clk_i) disable iff (cap_rst_reg)
    ##2 hold_lo_reg == $past(fall_reg, 2))
    else $error("falling sample not aligned into low half");

  chk_fifo_write_enabled: assert property (
    @(posedge cap_clk_i) disable iff (cap_rst_reg)
    fifo_push |-> $past(en_s2_reg, 2) && !fifo_full)
    else $error("FIFO written outside read window");

  // Checks in the system domain
  chk_fifo_pop_ready: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !fifo_empty && buf_in.ready |-> fifo_pop ##1 rbin_reg == $past(rbin_inc))
    else $error("pending word not moved to buffer");

  chk_mask_low_written: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_fire && wr_be_i[0] |=> !dm_lo_o[0] && dm_oe_o[0])
    else $error("written byte lane left masked");

  chk_mask_high_skipped: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_fire && mode == ddp_pkg::MODE_X8 && !wr_be_i[NB] |=> dm_hi_o[0])
    else $error("unwritten byte lane not masked");

  chk_dm_per_group: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    mode == ddp_pkg::MODE_X32 ##1 $stable(mode_i) |-> dm_oe_o[3:1] == 3'h0)
    else $error("mask line driven for absent group");

  chk_dm_dq_launch: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    mem_kind == ddp_pkg::MEM_SDRAM ##1 $stable(mem_qdr_i) |-> dm_oe_o[0] == dq_oe_o[0])
    else $error("mask not launched with data");

  chk_parity_line: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_fire && par_mode |=> dq_hi_o[PB] == ^$past(wr_data_i[DB+7:DB]))
    else $error("parity line wrong for byte zero");

  chk_extra_idle: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !par_mode ##1 $stable(mode_i) |-> dq_oe_o[DL-1:PB] == 4'h0)
    else $error("extra line driven outside parity mode");

  chk_qdr_select_held: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    mem_kind == ddp_pkg::MEM_QDR && !wr_fire ##1 $stable(mem_qdr_i) && $stable(mode_i)
      |-> dm_oe_o[0] && dm_hi_o[0] && dm_lo_o[0])
    else $error("idle byte-write select not held high");

  cov_read_delivered: cover property (
    @(posedge sys_clk_i) disable iff (rst_i) rd_valid_o && rd_ready_i);
  cov_read_stalled: cover property (
    @(posedge sys_clk_i) disable iff (rst_i) rd_valid_o && !rd_ready_i ##1 rd_valid_o);
  cov_parity_write: cover property (
    @(posedge sys_clk_i) disable iff (rst_i) wr_fire && par_mode);
  cov_fifo_overflow: cover property (
    @(posedge cap_clk_i) disable iff (cap_rst_reg) fifo_drop);
endmodule

// File: design/ddp_skid_buf.sv
`timescale 1ns/1ps
module ddp_skid_buf (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  ddp_stream_if.snk in_s,
  ddp_stream_if.src out_s
);
  logic [ddp_pkg::BUF_W-1:0] d0_reg, d0_next, d1_reg, d1_next;
  logic v0_reg, v0_next, v1_reg, v1_next;
  wire push = in_s.valid && !v1_reg;
  wire pop = v0_reg && out_s.ready;

  assign in_s.ready = !v1_reg;
  assign out_s.valid = v0_reg;
  assign out_s.data = d0_reg;

  always_comb begin
    d0_next = d0_reg;
    d1_next = d1_reg;
    v0_next = v0_reg;
    v1_next = v1_reg;
    if (pop) begin
      d0_next = v1_reg ? d1_reg : in_s.data;
      v0_next = v1_reg || push;
      v1_next = 1'b0;
    end else if (push && !v0_reg) begin
      d0_next = in_s.data;
      v0_next = 1'b1;
    end else if (push) begin
      d1_next = in_s.data;
      v1_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    d0_reg <= d0_next;
    d1_reg <= d1_next;
    v0_reg <= rst_i ? 1'b0 : v0_next;
    v1_reg <= rst_i ? 1'b0 : v1_next;
  end

  chk_stall_holds_word: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    v0_reg && !out_s.ready |=> v0_reg && $stable(d0_reg))
    else $error("buffered read word changed while stalled");
endmodule

// File: testbench/ddp_mem_model.sv
`timescale 1ns/1ps
module ddp_mem_model (
  input wire logic sys_clk_i,
  input wire logic cap_clk_i,
  input wire logic [2:0] mode_i,
  input wire logic [35:0] dq_hi_i,
  input wire logic [35:0] dq_lo_i,
  input wire logic [35:0] dq_oe_i,
  input wire logic [3:0] dm_hi_i,
  input wire logic [3:0] dm_lo_i,
  output logic [35:0] rd_dq_o
);
  logic [35:0] seq_reg = 36'h0;
  logic [31:0] mem_hi = 32'h0;
  logic [31:0] mem_lo = 32'h0;

  // Read data steps on every edge, no strobe returned
  always @(cap_clk_i) begin
    seq_reg <= seq_reg + 36'h1;
  end
  assign rd_dq_o = seq_reg;

  function automatic int grp(input logic [2:0] m, input int b);
    grp = (m < 3'h2) ? b : (m < 3'h4) ? b / 2 : 0;
  endfunction

  // Lane kept only while its mask line is low
  always @(posedge sys_clk_i) begin
    for (int b = 0; b < 4; b++) begin
      if (dq_oe_i[8*b] && !dm_hi_i[grp(mode_i, b)]) mem_hi[8*b+:8] <= dq_hi_i[8*b+:8];
      if (dq_oe_i[8*b] && !dm_lo_i[grp(mode_i, b)]) mem_lo[8*b+:8] <= dq_lo_i[8*b+:8];
    end
  end
endmodule

// File: testbench/ddr_memory_io_datapath_tb_top.sv
`timescale 1ns/1ps
module ddr_memory_io_datapath_tb_top;
  logic sys_clk = 0, cap_clk = 0, rst = 1, rd_en = 0, rd_ready = 0, ovf_clr = 0, mem_qdr = 0, wr_valid = 0;
  logic [2:0] mode = 3'h4;
  logic [63:0] wr_data = 64'h0;
  logic [7:0] wr_be = 8'h0;
  logic [71:0] rd_data;
  logic [7:0] par_err;
  logic rd_valid, ovf, wr_ready;
  logic [35:0] dq_hi, dq_lo, dq_oe, rd_dq;
  logic [3:0] dm_hi, dm_lo, dm_oe;
  int num_errors = 0;
  int checked = 0;

  always #4 sys_clk = ~sys_clk;
  initial begin
    #5;
    forever #24 cap_clk = ~cap_clk;
  end

  ddp_mem_io u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .cap_clk_i(cap_clk), .rd_dq_i(rd_dq), .rd_en_i(rd_en),
    .rd_data_o(rd_data), .rd_par_err_o(par_err), .rd_valid_o(rd_valid), .rd_ready_i(rd_ready),
    .rd_overflow_o(ovf), .ovf_clr_i(ovf_clr), .mode_i(mode), .mem_qdr_i(mem_qdr), .wr_valid_i(wr_valid),
    .wr_data_i(wr_data), .wr_be_i(wr_be), .wr_ready_o(wr_ready), .dq_hi_o(dq_hi), .dq_lo_o(dq_lo),
    .dq_oe_o(dq_oe), .dm_hi_o(dm_hi), .dm_lo_o(dm_lo), .dm_oe_o(dm_oe));

  ddp_mem_model u_mem (.sys_clk_i(sys_clk), .cap_clk_i(cap_clk), .mode_i(mode), .dq_hi_i(dq_hi),
    .dq_lo_i(dq_lo), .dq_oe_i(dq_oe), .dm_hi_i(dm_hi), .dm_lo_i(dm_lo), .rd_dq_o(rd_dq));

  task automatic check(input string what, input logic [71:0] got, input logic [71:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [3:0] grp_exp(input logic [2:0] m, input logic [3:0] be);
    if (m < 3'h2) return be;
    if (m < 3'h4) return {2'h0, |be[3:2], |be[1:0]};
    return {3'h0, |be};
  endfunction

  // Even parity error per byte of one 36-line half
  function automatic logic [3:0] perr_exp(input logic [35:0] h);
    for (int i = 0; i < 4; i++) perr_exp[i] = (^h[8*i+:8]) ^ h[32+i];
  endfunction

  task automatic t_write(input logic [2:0] m, input logic qdr, input logic [63:0] d, input logic [7:0] be);
    logic [3:0] ln, ph, pl;
    logic pon;
    ln = (m < 3'h2) ? 4'hF : (m < 3'h4) ? 4'h3 : 4'h1;
    pon = m[0] && (m < 3'h6);
    for (int i = 0; i < 4; i++) begin
      ph[i] = pon & ^d[32+8*i+:8];
      pl[i] = pon & ^d[8*i+:8];
    end
    @(posedge sys_clk);
    mode <= m;
    mem_qdr <= qdr;
    @(posedge sys_clk);
    wr_valid <= 1'b1;
    wr_data <= d;
    wr_be <= be;
    @(posedge sys_clk);
    wr_valid <= 1'b0;
    @(negedge sys_clk);
    check("wr_ready", wr_ready, 1'b1);
    check("dq_hi", dq_hi, {ph, d[63:32]});
    check("dq_lo", dq_lo, {pl, d[31:0]});
    check("dq_oe", dq_oe, {{4{pon}}, 32'hFFFFFFFF});
    check("dm_hi", dm_hi & ln, ~grp_exp(m, be[7:4]) & ln);
    check("dm_lo", dm_lo & ln, ~grp_exp(m, be[3:0]) & ln);
    check("dm_oe", dm_oe, ln);
    @(negedge sys_clk);
    check("dq_oe idle", dq_oe, 36'h0);
    check("dm_oe idle", dm_oe, qdr ? ln : 4'h0);
    if (qdr) check("dm idle", dm_hi & ln, ln);
    $display("write mode %0d qdr %0d done", m, qdr);
  endtask

  task automatic t_store();
    logic [63:0] d, e;
    d = 64'h1122_3344_5566_7788;
    for (int b = 0; b < 8; b++) e[8*b+:8] = (b == 1 || b == 6) ? d[8*b+:8] : 8'h00;
    t_write(3'h0, 1'b1, d, 8'h42);
    check("mem store", {u_mem.mem_hi, u_mem.mem_lo}, e);
  endtask

  task automatic t_read_stream(input logic [2:0] m);
    logic [35:0] prev;
    int got, cyc;
    got = 0;
    cyc = 0;
    @(posedge sys_clk);
    mode <= m;
    rd_en <= 1'b1;
    while (got < 12 && cyc < 600) begin
      @(negedge sys_clk);
      if (rd_valid === 1'b1 && rd_ready) begin
        check("pair", rd_data[71:36], rd_data[35:0] + 36'h1);
        if (got > 0) check("order", rd_data[35:0], prev + 36'h2);
        check("par_err", par_err, m[0] ? {perr_exp(rd_data[71:36]), perr_exp(rd_data[35:0])} : 8'h0);
        prev = rd_data[35:0];
        got++;
      end
      @(posedge sys_clk);
      rd_ready <= (cyc % 3 != 0);
      cyc++;
    end
    rd_en <= 1'b0;
    rd_ready <= 1'b1;
    check("words", got, 12);
    repeat (60) @(posedge sys_clk);
    rd_ready <= 1'b0;
    $display("read stream mode %0d done", m);
  endtask

  task automatic t_overflow();
    int n;
    n = 0;
    @(posedge sys_clk);
    rd_en <= 1'b1;
    repeat (80) @(posedge sys_clk);
    rd_en <= 1'b0;
    repeat (30) @(posedge sys_clk);
    @(negedge sys_clk);
    check("ovf set", ovf, 1'b1);
    @(posedge sys_clk);
    ovf_clr <= 1'b1;
    @(posedge sys_clk);
    ovf_clr <= 1'b0;
    rd_ready <= 1'b1;
    repeat (20) begin
      @(negedge sys_clk);
      if (rd_valid === 1'b1) n++;
    end
    check("ovf clr", ovf, 1'b0);
    check("drained", n, 6);
    $display("overflow done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    repeat (9) @(posedge sys_clk);
    @(negedge sys_clk);
    check("reset outs", {wr_ready, rd_valid, ovf, dq_oe, dm_oe}, 43'h0);
    @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    t_store();
    for (int m = 0; m < 7; m++) t_write(3'(m), 1'b0, 64'hA5C3_0F1E_7788_9B2D ^ 64'(m), 8'(m * 16) + 8'h0C);
    t_write(3'h3, 1'b1, 64'hFFEE_0102_0304_8001, 8'h81);
    t_read_stream(3'h4);
    t_read_stream(3'h5);
    t_overflow();
    conclude();
  end
endmodule
